/* File: ext_bus_defines.svh */
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH

`define ADDR_W        16
`define DATA_W        16
`define GLOBAL_ALLOC_REG_W        8
`define GLOBAL_ALLOC_REG_ADDR     16'h0005
`define GLOBAL_ALLOC_REG_RESET    8'h00
`define MMR_LAST      16'h0005

`endif

/* File: ext_bus_pkg.sv */
package ext_bus_pkg;
   typedef enum logic [1:0] {
      SPACE_PROG = 2'h0,
      SPACE_DATA = 2'h1,
      SPACE_IO   = 2'h2
   } space_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WAIT = 4'h2,
      ST_HOLD = 4'h4,
      ST_DONE = 4'h8
   } bus_state_t;
endpackage

/* File: global_alloc_reg_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface global_alloc_reg_if;
   logic [7:0]  alloc;
   logic [15:0] addr;
   logic        in_global;
   modport owner (output alloc, input addr, output in_global);
   modport user  (input alloc, output addr, input in_global);
endinterface
`default_nettype wire

/* File: global_region.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_defines.svh"
module global_region (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   global_alloc_reg_if.owner           gr
);
   import ext_bus_pkg::*;
   logic [7:0] global_alloc_reg;
   logic [7:0] next_global_alloc_reg;

   always_comb begin
      next_global_alloc_reg = wr_i ? wdata_i : global_alloc_reg;
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         global_alloc_reg <= `GLOBAL_ALLOC_REG_RESET;
      end else begin
         global_alloc_reg <= next_global_alloc_reg;
      end
   end

   assign gr.alloc = global_alloc_reg;
   // upper address byte at or above register value marks global region;
   // zero disables it
   assign gr.in_global = (global_alloc_reg != 8'h00) &&
                         (gr.addr[15:8] >= global_alloc_reg);
endmodule
`default_nettype wire

/* File: ext_bus_ctrl.sv */
// Function
// - i/o uses shared buses, distinct strobe
// - stall core until ready completes cycle
// - 8-bit register sizes global data region
// - assert bus request for global data access
// - ready sets global cycle length
// - hold low floats bus, acknowledges
// - allocation register mapped at data word five
// - ready at once means no wait cycle
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_defines.svh"
module ext_bus_ctrl (
   input  wire logic                 sys_clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 req_i,
   input  wire ext_bus_pkg::space_t  space_i,
   input  wire logic                 we_i,
   input  wire logic [15:0]          addr_i,
   input  wire logic [15:0]          wdata_i,
   output logic                      stall_o,
   output logic                      done_o,
   output logic [15:0]               rdata_o,
   output logic [15:0]               addr_o,
   output logic                      addr_oe_n_o,
   input  wire logic [15:0]          data_i,
   output logic [15:0]               data_o,
   output logic                      data_oe_n_o,
   output logic                      prog_strobe_n_o,
   output logic                      data_strobe_n_o,
   output logic                      io_strobe_n_o,
   output logic                      rw_o,
   output logic                      ctrl_oe_n_o,
   input  wire logic                 ready_i,
   output logic                      global_bus_request_n_o,
   input  wire logic                 hold_n_i,
   output logic                      hold_acknowledge_o
);
   import ext_bus_pkg::*;

   function automatic logic is_global_alloc_reg(input space_t sp, input logic [15:0] a);
      is_global_alloc_reg = (sp == SPACE_DATA) && (a == `GLOBAL_ALLOC_REG_ADDR);
   endfunction

   global_alloc_reg_if gr ();
   bus_state_t state, next_state;
   logic [15:0] addr_q, next_addr_q, wdata_q, next_wdata_q;
   logic [15:0] rdata_q, next_rdata_q;
   space_t      space_q, next_space_q;
   logic        we_q, next_we_q, br_q, next_br_q;
   logic        global_alloc_reg_hit;

   assign global_alloc_reg_hit = req_i && is_global_alloc_reg(space_i, addr_i);

   global_region u_region (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .wr_i      (global_alloc_reg_hit && we_i && state == ST_IDLE
                  && hold_n_i),
      .wdata_i   (wdata_i[7:0]),
      .gr        (gr)
   );
   assign gr.addr = addr_i;

   always_comb begin
      next_state   = state;
      next_addr_q  = addr_q;
      next_wdata_q = wdata_q;
      next_space_q = space_q;
      next_we_q    = we_q;
      next_br_q    = br_q;
      next_rdata_q = rdata_q;
      case (state)
         ST_IDLE: begin
            if (!hold_n_i) begin
               next_state = ST_HOLD;
            end else if (global_alloc_reg_hit) begin
               next_rdata_q = {8'h00, gr.alloc};
               next_state   = ST_DONE;
            end else if (req_i) begin
               next_addr_q  = addr_i;
               next_wdata_q = wdata_i;
               next_space_q = space_i;
               next_we_q    = we_i;
               // request only for global data accesses
               next_br_q = (space_i == SPACE_DATA) && gr.in_global
                           && addr_i > `MMR_LAST;
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // cycle ends on ready; first cycle sampled ready is zero-wait
            if (ready_i) begin
               next_rdata_q = data_i;
               next_br_q    = 1'b0;
               next_state   = ST_DONE;
            end
         end
         ST_DONE: begin
            // hold only honoured between cycles, never mid-cycle
            next_state = hold_n_i ? ST_IDLE : ST_HOLD;
         end
         ST_HOLD: begin
            if (hold_n_i) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state   <= ST_IDLE;
         addr_q  <= 16'h0000;
         wdata_q <= 16'h0000;
         rdata_q <= 16'h0000;
         space_q <= SPACE_PROG;
         we_q    <= 1'b0;
         br_q    <= 1'b0;
      end else begin
         state   <= next_state;
         addr_q  <= next_addr_q;
         wdata_q <= next_wdata_q;
         rdata_q <= next_rdata_q;
         space_q <= next_space_q;
         we_q    <= next_we_q;
         br_q    <= next_br_q;
      end
   end

   logic active, floating;
   assign active   = (state == ST_WAIT);
   assign floating = (state == ST_HOLD);

   assign stall_o  = req_i && (state != ST_DONE);
   assign done_o   = (state == ST_DONE);
   assign rdata_o  = rdata_q;
   assign addr_o   = addr_q;
   assign data_o   = wdata_q;
   assign rw_o     = !we_q;
   assign addr_oe_n_o = floating;
   assign ctrl_oe_n_o = floating;
   assign data_oe_n_o = !(active && we_q);
   assign prog_strobe_n_o = !(active && space_q == SPACE_PROG);
   assign data_strobe_n_o = !(active && space_q == SPACE_DATA);
   assign io_strobe_n_o   = !(active && space_q == SPACE_IO);
   assign global_bus_request_n_o = !(active && br_q);
   assign hold_acknowledge_o = floating;

   a_hold_ack_float: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) hold_acknowledge_o |-> addr_oe_n_o && ctrl_oe_n_o
      && data_oe_n_o) else $error("bus driven under hold ack");
   a_hold_no_mid: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) active && !ready_i |=> !hold_acknowledge_o)
      else $error("hold taken mid cycle");
   a_hold_release: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) hold_acknowledge_o && hold_n_i |=> !hold_acknowledge_o)
      else $error("hold ack not released");
   a_hold_grant: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) state == ST_IDLE && !hold_n_i |=> hold_acknowledge_o)
      else $error("hold not acknowledged");
   a_wait_ready: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) active && !ready_i |=> active)
      else $error("cycle ended without ready");
   a_zero_wait: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) active && ready_i |=> done_o)
      else $error("wait inserted with ready");
   a_br_data_only: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) !global_bus_request_n_o |-> !data_strobe_n_o
      && prog_strobe_n_o && io_strobe_n_o)
      else $error("request outside data access");
   a_io_distinct: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) !io_strobe_n_o |-> data_strobe_n_o && prog_strobe_n_o)
      else $error("io strobe overlaps memory");
   a_global_alloc_reg_write: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) state == ST_IDLE && hold_n_i && global_alloc_reg_hit && we_i
      |=> gr.alloc == $past(wdata_i[7:0]))
      else $error("allocation write lost");

   // a done strobe longer than one cycle would let the core retire twice
   a_done_pulse: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) done_o |=> !done_o)
      else $error("done longer than one cycle");

   // address must not wander while the far side is still answering
   a_addr_steady: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) active && !ready_i |=> $stable(addr_o))
      else $error("address moved in wait");

   // register access is internal, so no strobe may reach the pins
   a_global_alloc_reg_no_bus: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) state == ST_IDLE && hold_n_i && global_alloc_reg_hit
      |=> prog_strobe_n_o && data_strobe_n_o && io_strobe_n_o)
      else $error("allocation access on bus");

   // request is only meaningful inside a running cycle
   a_br_idle_off: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) !active |-> global_bus_request_n_o)
      else $error("request outside a cycle");

   // a global data access must raise the request in its first cycle
   a_br_region: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) state == ST_IDLE && hold_n_i && req_i && !global_alloc_reg_hit
      && space_i == SPACE_DATA && gr.in_global && addr_i > `MMR_LAST
      |=> !global_bus_request_n_o)
      else $error("global access without request");

   // data pins only driven on writes, so direction must agree
   a_rw_write: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) !data_oe_n_o |-> !rw_o)
      else $error("data driven on a read");

   // outside hold the address and control pins stay driven
   a_own_bus: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) !hold_acknowledge_o |-> !addr_oe_n_o && !ctrl_oe_n_o)
      else $error("bus floated without hold");
endmodule
`default_nettype wire

/* File: ext_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module ext_partner (
   input  wire logic        sys_clk_i,
   input  wire logic        sel_n_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [3:0]  delay_i,
   output logic             ready_o,
   output logic [15:0]      data_o
);
   logic [3:0] count = 4'h0;
   logic       tog   = 1'b0;
   always_ff @(posedge sys_clk_i) begin
      count <= sel_n_i ? 4'h0 : count + 4'h1;
      tog   <= ~tog;
   end
   // one requester here, so the grant is just a late ready
   assign ready_o = !sel_n_i && (count >= delay_i);
   // released bus keeps changing so stale data never looks valid
   assign data_o = sel_n_i ? {8{tog, ~tog}} : ~addr_i;
endmodule
`default_nettype wire

/* File: external_bus_global_mem_hold_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   fails++; $display("BAD %s expected %h seen %h", n, e, g); end end
module external_bus_global_mem_hold_bench;
   import ext_bus_pkg::*;
   logic        sys_clk = 1'b0, reset = 1'b1, req = 1'b0, we = 1'b0;
   logic        hold_n  = 1'b1;
   space_t      space   = SPACE_PROG;
   logic [15:0] addr = 16'h0000, wdata = 16'hff80, rdata, data_in;
   logic [15:0] ext_addr, ext_data;
   logic        rw;
   logic [3:0]  dly = 4'h0;
   logic        stall, done, ready, p_st, d_st, i_st, br, ack;
   logic        a_oe, d_oe, c_oe;
   int          fails = 0, check_count = 0;
   always #25 sys_clk = ~sys_clk;
   ext_bus_ctrl u_ext_bus_ctrl (.sys_clk_i(sys_clk), .reset_i(reset),
      .req_i(req), .space_i(space), .we_i(we), .addr_i(addr),
      .wdata_i(wdata), .stall_o(stall), .done_o(done), .rdata_o(rdata),
      .addr_o(ext_addr), .addr_oe_n_o(a_oe), .data_i(data_in),
      .data_o(ext_data),
      .data_oe_n_o(d_oe), .prog_strobe_n_o(p_st), .data_strobe_n_o(d_st),
      .io_strobe_n_o(i_st), .rw_o(rw), .ctrl_oe_n_o(c_oe), .ready_i(ready),
      .global_bus_request_n_o(br), .hold_n_i(hold_n),
      .hold_acknowledge_o(ack));
   ext_partner u_ext_partner (.sys_clk_i(sys_clk),
      .sel_n_i(p_st & d_st & i_st), .addr_i(addr), .delay_i(dly),
      .ready_o(ready), .data_o(data_in));
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // en: cycles to done; es: stall and strobes seen in first cycle
   task automatic xfer(input space_t sp, input logic w, input logic [15:0] a,
         input logic [3:0] dl, input int en, input logic [4:0] es);
      int         n;
      logic [4:0] st;
      logic [33:0] bus;
      n = 0;
      st = 5'h00;
      bus = 34'h0;
      space <= sp;
      we <= w;
      addr <= a;
      dly <= dl;
      req <= 1'b1;
      do begin
         @(posedge sys_clk);
         #1 n++;
         if (n == 1) begin
            st = {stall, p_st, d_st, i_st, br};
            bus = {ext_addr, ext_data, rw, d_oe};
         end
      end while (done !== 1'b1 && n < 20);
      if (!w)
         `CHK("read data", (a == 16'h0005) ? 16'h0080 : ~a, rdata)
      `CHK("cycles", en, n)
      `CHK("strobes", es, st)
      if (a != 16'h0005) begin
         `CHK("address out", a, bus[33:18])
         `CHK("direction", {!w, !w}, bus[1:0])
         if (w)
            `CHK("write data", wdata, bus[17:2])
      end
      @(posedge sys_clk);
      req <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic t_global_alloc_reg();
      xfer(SPACE_DATA, 1'b1, 16'h0005, 4'h0, 1, 5'h0f);
      xfer(SPACE_DATA, 1'b0, 16'h0005, 4'h0, 1, 5'h0f);
      $display("allocation test done");
   endtask
   task automatic t_spaces();
      xfer(SPACE_DATA, 1'b0, 16'h9000, 4'h3, 5, 5'h1a);
      xfer(SPACE_DATA, 1'b0, 16'h1000, 4'h0, 2, 5'h1b);
      xfer(SPACE_IO, 1'b0, 16'h0003, 4'h1, 3, 5'h1d);
      xfer(SPACE_PROG, 1'b0, 16'hc000, 4'h0, 2, 5'h17);
      xfer(SPACE_DATA, 1'b1, 16'h1000, 4'h2, 4, 5'h1b);
      $display("space test done");
   endtask
   task automatic t_hold();
      hold_n <= 1'b0;
      space <= SPACE_DATA;
      we <= 1'b0;
      addr <= 16'h1000;
      dly <= 4'h0;
      req <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 `CHK("hold float", 4'hf, {ack, a_oe, d_oe, c_oe})
      `CHK("refused under hold", 2'b11, {stall, d_st})
      @(posedge sys_clk);
      hold_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 `CHK("hold release", 2'b01, {ack, done})
      @(posedge sys_clk);
      req <= 1'b0;
      @(posedge sys_clk);
      $display("hold test done");
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_global_alloc_reg();
      t_spaces();
      t_hold();
      conclude();
   end
   initial begin
      repeat (2000) @(posedge sys_clk);
      fails++;
      conclude();
   end
endmodule
`default_nettype wire
